// *** src/lpcx_pkg.sv ***
// Purpose: Shared constants, field positions and types for the low-power co-processor core
// Assumes: 32-bit instruction words, 16-bit general registers, word-addressed shared RAM
// Notes: Field positions are given as hi/lo pairs so the decode reads as plain part-selects
package lpcx_pkg;
    localparam int DATA_W = 16;
    localparam int INSTR_W = 32;
    localparam int MEM_AW = 11;
    localparam int PC_W = 11;
    localparam int STAGE_W = 8;
    localparam int RIDX_W = 2;
    localparam int NUM_GPR = 4;

    // Host view of shared RAM word 0
    localparam logic [31:0] HOST_BASE_ADDR = 32'h5000_0000;

    // Major opcode and sub-type fields
    localparam int OP_HI = 31;
    localparam int OP_LO = 28;
    localparam int SUB_HI = 27;
    localparam int SUB_LO = 25;
    localparam int SEL_HI = 24;
    localparam int SEL_LO = 21;
    localparam logic [3:0] OPC_ALU = 4'h7;
    localparam logic [3:0] OPC_STORE = 4'h6;
    localparam logic [3:0] OPC_LOAD = 4'hD;
    localparam logic [3:0] OPC_JUMP = 4'h8;
    localparam logic [2:0] SUB_ALU_REG = 3'h0;
    localparam logic [2:0] SUB_ALU_IMM = 3'h1;
    localparam logic [2:0] SUB_ALU_STAGE = 3'h2;
    localparam logic [2:0] SUB_STORE = 3'h4;
    localparam logic [2:0] SUB_JUMP_ABS = 3'h0;
    localparam logic [2:0] SUB_JUMP_REL = 3'h1;

    // Register index fields
    localparam int RD_HI = 1;
    localparam int RD_LO = 0;
    localparam int RA_HI = 3;
    localparam int RA_LO = 2;
    localparam int RB_HI = 5;
    localparam int RB_LO = 4;
    localparam int IMM_HI = 19;
    localparam int IMM_LO = 4;
    localparam int SIMM_HI = 11;
    localparam int SIMM_LO = 4;
    localparam int OFS_HI = 19;
    localparam int OFS_LO = 10;
    localparam int OFS_W = 10;
    localparam int STORE_PC_SHIFT = 5;

    // Jump fields
    localparam int JSEL_BIT = 21;
    localparam int JTYPE_HI = 24;
    localparam int JTYPE_LO = 22;
    localparam int JADDR_HI = 14;
    localparam int JADDR_LO = 2;
    localparam int STEP_HI = 24;
    localparam int STEP_LO = 17;
    localparam int STEP_DIR_BIT = 7;
    localparam int STEP_MAG_HI = 6;
    localparam int JCOND_BIT = 16;
    localparam int THR_HI = 15;
    localparam int THR_LO = 0;
    localparam logic [2:0] JT_ALWAYS = 3'h0;
    localparam logic [2:0] JT_ZERO = 3'h1;
    localparam logic [2:0] JT_OVF = 3'h2;

    // Register port map
    localparam logic [2:0] RA_PC = 3'h4;
    localparam logic [2:0] RA_STAGE = 3'h5;
    localparam logic [2:0] RA_FLAGS = 3'h6;
    localparam logic [2:0] RA_CTRL = 3'h7;
    localparam int CTRL_RUN_BIT = 0;
    localparam int FLAG_ZERO_BIT = 0;
    localparam int FLAG_OVF_BIT = 1;

    typedef enum logic [3:0] {
        LPCX_ADD = 4'h0,
        LPCX_SUB = 4'h1,
        LPCX_AND = 4'h2,
        LPCX_OR = 4'h3,
        LPCX_MOVE = 4'h4,
        LPCX_SHIFT_LEFT = 4'h5,
        LPCX_SHIFT_RIGHT = 4'h6
    } lpcx_alu_op_t;

    localparam logic [3:0] STG_INC = 4'h0;
    localparam logic [3:0] STG_DEC = 4'h1;
    localparam logic [3:0] STG_CLR = 4'h2;

    // Gray sequence along fetch, wait, execute, data wait
    typedef enum logic [1:0] {
        LPCX_FETCH = 2'h0,
        LPCX_IWAIT = 2'h1,
        LPCX_EXEC = 2'h3,
        LPCX_DWAIT = 2'h2
    } lpcx_state_t;

    typedef struct packed {
        logic we;
        logic [MEM_AW-1:0] addr;
        logic [INSTR_W-1:0] wdata;
    } lpcx_mem_req_t;
endpackage : lpcx_pkg

// *** src/lpcx_alu.sv ***
// Purpose: 16-bit arithmetic and logic unit of the co-processor
// Assumes: Operand b is already the register or the immediate
// Notes: Overflow is the carry or borrow out of bit 15
`timescale 1ns/1ps
module lpcx_alu (
    input wire logic [3:0] op_in,
    input wire logic imm_form_in,
    input wire logic [15:0] a_in,
    input wire logic [15:0] b_in,
    output logic [15:0] result_out,
    output logic ovf_out,
    output logic valid_out,
    output logic arith_out
);
    logic [16:0] wide;

    // Operation select picks the function
    always_comb begin
        wide = 17'h0_0000;
        valid_out = 1'b1;
        arith_out = 1'b0;
        result_out = 16'h0000;
        case (op_in)
            lpcx_pkg::LPCX_ADD: begin
                wide = {1'b0, a_in} + {1'b0, b_in};
                arith_out = 1'b1;
                result_out = wide[15:0];
            end
            lpcx_pkg::LPCX_SUB: begin
                wide = {1'b0, a_in} - {1'b0, b_in};
                arith_out = 1'b1;
                result_out = wide[15:0];
            end
            lpcx_pkg::LPCX_AND: result_out = a_in & b_in;
            lpcx_pkg::LPCX_OR: result_out = a_in | b_in;
            lpcx_pkg::LPCX_MOVE: result_out = imm_form_in ? b_in : a_in; // Immediate form loads imm
            lpcx_pkg::LPCX_SHIFT_LEFT: result_out = a_in << b_in; // Amounts of 16 up give zero
            lpcx_pkg::LPCX_SHIFT_RIGHT: result_out = a_in >> b_in;
            default: valid_out = 1'b0; // Codes 7..15 do nothing
        endcase
        ovf_out = wide[16];
    end
endmodule : lpcx_alu

// *** src/lpcx_branch.sv ***
// Purpose: Jump decode and target arithmetic for absolute and relative jumps
// Assumes: Program counter and all targets count 32-bit words
// Notes: Unknown jump types never branch
`timescale 1ns/1ps
module lpcx_branch (
    input wire logic [31:0] instr_in,
    input wire logic [lpcx_pkg::PC_W-1:0] pc_in,
    input wire logic [15:0] first_general_reg_in,
    input wire logic [15:0] target_reg_in,
    input wire logic zero_in,
    input wire logic ovf_in,
    output logic jump_out,
    output logic taken_out,
    output logic [lpcx_pkg::PC_W-1:0] target_out
);
    logic [2:0] sub;
    logic [2:0] jtype;
    logic [7:0] step;
    logic [lpcx_pkg::PC_W-1:0] absolute_target;
    logic [lpcx_pkg::PC_W-1:0] mag;
    logic [15:0] thr;
    logic abs_jump;
    logic rel_jump;

    assign sub = instr_in[lpcx_pkg::SUB_HI:lpcx_pkg::SUB_LO];
    assign jtype = instr_in[lpcx_pkg::JTYPE_HI:lpcx_pkg::JTYPE_LO];
    assign step = instr_in[lpcx_pkg::STEP_HI:lpcx_pkg::STEP_LO];
    assign thr = instr_in[lpcx_pkg::THR_HI:lpcx_pkg::THR_LO];
    assign mag = lpcx_pkg::PC_W'(step[lpcx_pkg::STEP_MAG_HI:0]);
    assign absolute_target = lpcx_pkg::PC_W'(instr_in[lpcx_pkg::JADDR_HI:lpcx_pkg::JADDR_LO]);
    assign abs_jump = (instr_in[lpcx_pkg::OP_HI:lpcx_pkg::OP_LO] == lpcx_pkg::OPC_JUMP)
                      && (sub == lpcx_pkg::SUB_JUMP_ABS);
    assign rel_jump = (instr_in[lpcx_pkg::OP_HI:lpcx_pkg::OP_LO] == lpcx_pkg::OPC_JUMP)
                      && (sub == lpcx_pkg::SUB_JUMP_REL);
    assign jump_out = abs_jump | rel_jump;

    // Condition and target selection
    always_comb begin
        taken_out = 1'b0;
        target_out = pc_in;
        if (abs_jump) begin
            target_out = instr_in[lpcx_pkg::JSEL_BIT] ? lpcx_pkg::PC_W'(target_reg_in)
                                                       : absolute_target;
            case (jtype)
                lpcx_pkg::JT_ALWAYS: taken_out = 1'b1;
                lpcx_pkg::JT_ZERO: taken_out = zero_in;
                lpcx_pkg::JT_OVF: taken_out = ovf_in;
                default: taken_out = 1'b0;
            endcase
        end else if (rel_jump) begin
            // Step in words, sign-magnitude
            target_out = step[lpcx_pkg::STEP_DIR_BIT] ? pc_in - mag : pc_in + mag;
            taken_out = instr_in[lpcx_pkg::JCOND_BIT] ? (first_general_reg_in >= thr)
                                                       : (first_general_reg_in < thr);
        end
    end
endmodule : lpcx_branch

// *** src/lpcx_core.sv ***
// Purpose: Fetch, decode and execute of ALU, stage counter, load, store and jump instructions
// Assumes: Shared RAM answers every read with one rvalid pulse, writes need no answer
// Notes: Other opcodes are skipped as no-ops; ce_in low freezes every flip-flop
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module lpcx_core (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_we_in,
    input wire logic reg_re_in,
    output logic [15:0] reg_rdata_out,
    output logic mem_valid_out,
    output lpcx_pkg::lpcx_mem_req_t mem_req_out,
    input wire logic [31:0] mem_rdata_in,
    input wire logic mem_rvalid_in
);
    lpcx_pkg::lpcx_state_t state_q;
    logic [15:0] gpr_q [lpcx_pkg::NUM_GPR];
    logic [lpcx_pkg::PC_W-1:0] pc_q;
    logic [lpcx_pkg::STAGE_W-1:0] stage_q;
    logic zero_q;
    logic ovf_q;
    logic run_q;
    logic [31:0] instr_q;
    logic [1:0] load_dst_q;
    logic mem_valid_q;
    lpcx_pkg::lpcx_mem_req_t mem_req_q;
    logic [15:0] rdata_q;

    logic exec;
    logic [3:0] opc;
    logic [2:0] sub;
    logic [3:0] sel;
    logic [15:0] reg_a;
    logic [15:0] reg_b;
    logic [15:0] reg_d;
    logic [15:0] imm16;
    logic [7:0] imm8;
    logic [15:0] alu_b;
    logic [15:0] alu_res;
    logic alu_ovf;
    logic alu_ok;
    logic alu_arith;
    logic alu_do;
    logic stage_do;
    logic store_do;
    logic load_do;
    logic br_jump;
    logic br_taken;
    logic [lpcx_pkg::PC_W-1:0] br_target;
    logic [lpcx_pkg::PC_W-1:0] pc_next;

    // Word address from a 16-bit base and a signed word offset
    function automatic logic [lpcx_pkg::MEM_AW-1:0] word_addr(input logic [15:0] base,
                                                              input logic [lpcx_pkg::OFS_W-1:0] ofs);
        logic [15:0] sum;
        sum = base + {{(16 - lpcx_pkg::OFS_W){ofs[lpcx_pkg::OFS_W-1]}}, ofs};
        return sum[lpcx_pkg::MEM_AW-1:0];
    endfunction : word_addr

    // Field decode of the held instruction
    assign exec = (state_q == lpcx_pkg::LPCX_EXEC);
    assign opc = instr_q[lpcx_pkg::OP_HI:lpcx_pkg::OP_LO];
    assign sub = instr_q[lpcx_pkg::SUB_HI:lpcx_pkg::SUB_LO];
    assign sel = instr_q[lpcx_pkg::SEL_HI:lpcx_pkg::SEL_LO];
    assign reg_a = gpr_q[instr_q[lpcx_pkg::RA_HI:lpcx_pkg::RA_LO]];
    assign reg_b = gpr_q[instr_q[lpcx_pkg::RB_HI:lpcx_pkg::RB_LO]];
    assign reg_d = gpr_q[instr_q[lpcx_pkg::RD_HI:lpcx_pkg::RD_LO]];
    assign imm16 = instr_q[lpcx_pkg::IMM_HI:lpcx_pkg::IMM_LO];
    assign imm8 = instr_q[lpcx_pkg::SIMM_HI:lpcx_pkg::SIMM_LO];
    assign alu_b = (sub == lpcx_pkg::SUB_ALU_IMM) ? imm16 : reg_b;
    assign alu_do = exec && (opc == lpcx_pkg::OPC_ALU) && alu_ok
                    && ((sub == lpcx_pkg::SUB_ALU_REG) || (sub == lpcx_pkg::SUB_ALU_IMM));
    assign stage_do = exec && (opc == lpcx_pkg::OPC_ALU) && (sub == lpcx_pkg::SUB_ALU_STAGE);
    assign store_do = exec && (opc == lpcx_pkg::OPC_STORE) && (sub == lpcx_pkg::SUB_STORE);
    assign load_do = exec && (opc == lpcx_pkg::OPC_LOAD);
    assign pc_next = (br_jump && br_taken) ? br_target : pc_q + 1'b1;

    lpcx_alu u_alu (
        .op_in(sel),
        .imm_form_in(sub == lpcx_pkg::SUB_ALU_IMM),
        .a_in(reg_a),
        .b_in(alu_b),
        .result_out(alu_res),
        .ovf_out(alu_ovf),
        .valid_out(alu_ok),
        .arith_out(alu_arith)
    );

    lpcx_branch u_branch (
        .instr_in(instr_q),
        .pc_in(pc_q),
        .first_general_reg_in(gpr_q[0]),
        .target_reg_in(reg_d),
        .zero_in(zero_q),
        .ovf_in(ovf_q),
        .jump_out(br_jump),
        .taken_out(br_taken),
        .target_out(br_target)
    );

    // Sequencer: fetch, wait for word, execute, wait for load data
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= lpcx_pkg::LPCX_FETCH;
        end else if (ce_in) begin
            case (state_q)
                lpcx_pkg::LPCX_FETCH: if (run_q) state_q <= lpcx_pkg::LPCX_IWAIT;
                lpcx_pkg::LPCX_IWAIT: if (mem_rvalid_in) state_q <= lpcx_pkg::LPCX_EXEC;
                lpcx_pkg::LPCX_EXEC: state_q <= load_do ? lpcx_pkg::LPCX_DWAIT : lpcx_pkg::LPCX_FETCH;
                lpcx_pkg::LPCX_DWAIT: if (mem_rvalid_in) state_q <= lpcx_pkg::LPCX_FETCH;
                default: state_q <= lpcx_pkg::LPCX_FETCH;
            endcase
        end
    end

    // Instruction capture, one full word per fetch
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            instr_q <= 32'h0000_0000;
        end else if (ce_in && state_q == lpcx_pkg::LPCX_IWAIT && mem_rvalid_in) begin
            instr_q <= mem_rdata_in;
        end
    end

    // Memory requests: whole words only, one-cycle valid pulse
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_valid_q <= 1'b0;
            mem_req_q <= '0;
            load_dst_q <= 2'h0;
        end else if (ce_in) begin
            mem_valid_q <= 1'b0;
            if (state_q == lpcx_pkg::LPCX_FETCH && run_q) begin
                mem_valid_q <= 1'b1;
                mem_req_q.we <= 1'b0;
                mem_req_q.addr <= pc_q;
            end else if (store_do) begin
                mem_valid_q <= 1'b1;
                mem_req_q.we <= 1'b1;
                mem_req_q.addr <= word_addr(reg_a, instr_q[lpcx_pkg::OFS_HI:lpcx_pkg::OFS_LO]);
                mem_req_q.wdata <= {16'(pc_q) << lpcx_pkg::STORE_PC_SHIFT, reg_d};
            end else if (load_do) begin
                mem_valid_q <= 1'b1;
                mem_req_q.we <= 1'b0;
                mem_req_q.addr <= word_addr(reg_a, instr_q[lpcx_pkg::OFS_HI:lpcx_pkg::OFS_LO]);
                load_dst_q <= instr_q[lpcx_pkg::RD_HI:lpcx_pkg::RD_LO];
            end
        end
    end

    // General registers: ALU results and load data
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < lpcx_pkg::NUM_GPR; i++) gpr_q[i] <= 16'h0000;
        end else if (ce_in) begin
            if (alu_do) begin
                gpr_q[instr_q[lpcx_pkg::RD_HI:lpcx_pkg::RD_LO]] <= alu_res;
            end else if (state_q == lpcx_pkg::LPCX_DWAIT && mem_rvalid_in) begin
                gpr_q[load_dst_q] <= mem_rdata_in[15:0];
            end
        end
    end

    // Flags change only on register or immediate ALU operations
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            zero_q <= 1'b0;
            ovf_q <= 1'b0;
        end else if (ce_in && alu_do) begin
            zero_q <= (alu_res == 16'h0000);
            if (alu_arith) ovf_q <= alu_ovf;
        end
    end

    // Stage counter, wraps modulo 256
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage_q <= 8'h00;
        end else if (ce_in && stage_do) begin
            case (sel)
                lpcx_pkg::STG_INC: stage_q <= stage_q + imm8;
                lpcx_pkg::STG_DEC: stage_q <= stage_q - imm8;
                lpcx_pkg::STG_CLR: stage_q <= 8'h00;
                default: stage_q <= stage_q;
            endcase
        end
    end

    // Program counter; software may load it only while stopped
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pc_q <= '0;
        end else if (ce_in) begin
            if (exec) begin
                pc_q <= pc_next;
            end else if (reg_we_in && reg_addr_in == lpcx_pkg::RA_PC && !run_q) begin
                pc_q <= reg_wdata_in[lpcx_pkg::PC_W-1:0];
            end
        end
    end

    // Run control bit
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_q <= 1'b0;
        end else if (ce_in && reg_we_in && reg_addr_in == lpcx_pkg::RA_CTRL) begin
            run_q <= reg_wdata_in[lpcx_pkg::CTRL_RUN_BIT];
        end
    end

    // Read port, data valid the cycle after the strobe only
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 16'h0000;
        end else if (ce_in) begin
            rdata_q <= 16'h0000;
            if (reg_re_in) begin
                case (reg_addr_in)
                    lpcx_pkg::RA_PC: rdata_q <= 16'(pc_q);
                    lpcx_pkg::RA_STAGE: rdata_q <= 16'(stage_q);
                    lpcx_pkg::RA_FLAGS: rdata_q <= 16'({ovf_q, zero_q});
                    lpcx_pkg::RA_CTRL: rdata_q <= 16'(run_q);
                    default: rdata_q <= gpr_q[reg_addr_in[1:0]];
                endcase
            end
        end
    end

    assign reg_rdata_out = rdata_q;
    assign mem_valid_out = mem_valid_q;
    assign mem_req_out = mem_req_q;

    chk_zero_flag_set: assert property (@(posedge clk_in) disable iff (rst_in)
        (ce_in && alu_do) |=> (zero_q == ($past(alu_res) == 16'h0000)))
        else $error("zero flag does not follow ALU result");
    chk_ovf_logic_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        (ce_in && alu_do && !alu_arith) |=> $stable(ovf_q))
        else $error("overflow flag changed on a logic operation");
    chk_flags_non_alu: assert property (@(posedge clk_in) disable iff (rst_in)
        (ce_in && exec && opc != lpcx_pkg::OPC_ALU) |=> ($stable(zero_q) && $stable(ovf_q)))
        else $error("flags changed on a non-ALU instruction");
    chk_store_pc_tag: assert property (@(posedge clk_in) disable iff (rst_in)
        (mem_valid_q && mem_req_q.we)
        |-> (mem_req_q.wdata[31:16] == (16'(pc_q - 1'b1) << lpcx_pkg::STORE_PC_SHIFT)))
        else $error("store upper half is not the shifted program counter");
    chk_stage_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        (ce_in && stage_do && sel == lpcx_pkg::STG_CLR) |=> (stage_q == 8'h00))
        else $error("stage counter not cleared");
    chk_load_low_half: assert property (@(posedge clk_in) disable iff (rst_in)
        (ce_in && state_q == lpcx_pkg::LPCX_DWAIT && mem_rvalid_in)
        |=> (gpr_q[$past(load_dst_q)] == $past(mem_rdata_in[15:0])))
        else $error("load did not copy the low half-word");
    chk_fetch_at_pc: assert property (@(posedge clk_in) disable iff (rst_in)
        (mem_valid_q && state_q == lpcx_pkg::LPCX_IWAIT) |-> (!mem_req_q.we && mem_req_q.addr == pc_q))
        else $error("fetch address differs from program counter");
    chk_jump_target: assert property (@(posedge clk_in) disable iff (rst_in)
        (ce_in && exec && br_jump && br_taken) |=> (pc_q == $past(br_target)) ##1 (mem_req_q.addr == pc_q))
        else $error("taken jump did not reach its target");
endmodule : lpcx_core

// *** verif/lpcx_ram_model.sv ***
// Purpose: Shared word RAM seen from the core's memory link
// Assumes: One read outstanding at a time, writes need no answer
// Notes: slow_in stretches each read answer by three cycles
`timescale 1ns/1ps
module lpcx_ram_model (
    input wire logic clk_in,
    input wire logic slow_in,
    input wire logic valid_in,
    input wire lpcx_pkg::lpcx_mem_req_t req_in,
    output logic [31:0] rdata_out,
    output logic rvalid_out
);
    logic [31:0] mem [0:2047];
    logic [lpcx_pkg::MEM_AW-1:0] addr_q;
    logic pend_q = 1'b0;
    logic [1:0] wait_q = 2'h0;
    initial rvalid_out = 1'b0;
    initial rdata_out = 32'h0;
    // Whole-word access only; idle data toggles so stale values never look valid
    always @(posedge clk_in) begin
        rvalid_out <= 1'b0;
        rdata_out <= ~rdata_out;
        if (valid_in && req_in.we) begin
            mem[req_in.addr] <= req_in.wdata;
        end else if (valid_in) begin
            pend_q <= 1'b1;
            addr_q <= req_in.addr;
            wait_q <= slow_in ? 2'h3 : 2'h0;
        end else if (pend_q && wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end else if (pend_q) begin
            pend_q <= 1'b0;
            rvalid_out <= 1'b1;
            rdata_out <= mem[addr_q];
        end
    end
endmodule : lpcx_ram_model

// *** verif/lpcx_core_test.sv ***
// Purpose: Self-checking bench running short programs through the core
// Assumes: General registers only writable through instructions
// Notes: Each trial ends in a self-loop at word 11, then the core is stopped
`timescale 1ns/1ps
module lpcx_core_test;
    logic clk_in, rst_in, reg_we_in, reg_re_in, mem_rvalid_in, mem_valid_out, slow;
    logic [2:0] reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out;
    logic [31:0] mem_rdata_in, rng;
    lpcx_pkg::lpcx_mem_req_t mem_req_out;
    int fail_count, checked;
    logic [7:0] lpcx_core_test_stage;
    logic [15:0] ra, rb;
    localparam logic [31:0] FILL = 32'hA5A5A5A5;
    lpcx_core lpcx_core_inst (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_we_in(reg_we_in), .reg_re_in(reg_re_in), .reg_rdata_out(reg_rdata_out),
        .mem_valid_out(mem_valid_out), .mem_req_out(mem_req_out), .mem_rdata_in(mem_rdata_in),
        .mem_rvalid_in(mem_rvalid_in));
    lpcx_ram_model lpcx_ram_model_inst (.clk_in(clk_in), .slow_in(slow), .valid_in(mem_valid_out),
        .req_in(mem_req_out), .rdata_out(mem_rdata_in), .rvalid_out(mem_rvalid_in));
    // Free-running 4 ns clock
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    function logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd
    function logic [16:0] alu_exp(input logic [3:0] op, input logic [15:0] x, input logic [15:0] y);
        case (op)
            4'h0: return {1'b0, x} + {1'b0, y};
            4'h1: return {1'b0, x} - {1'b0, y};
            4'h2: return {1'b0, x & y};
            4'h3: return {1'b0, x | y};
            4'h4: return {1'b0, x};
            4'h5: return {1'b0, x << y};
            default: return {1'b0, x >> y};
        endcase
    endfunction : alu_exp
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task complete_run();
        $display("Counts: %0d checked, %0d mismatches", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task reg_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_we_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_we_in <= 1'b0;
    endtask : reg_wr
    task reg_chk(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        reg_re_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_re_in <= 1'b0;
        #1 check({16'h0, reg_rdata_out}, {16'h0, exp});
    endtask : reg_chk
    // One program: stage op, moves, ALU op, store, conditional jumps, load, self-loop
    task trial(input logic [3:0] op, input logic [15:0] a, input logic [15:0] b, input logic imf, input logic [2:0] jt);
        logic [15:0] a2, c, t, res;
        logic [16:0] e;
        logic [7:0] si;
        logic [3:0] ss;
        logic zf, of, cd, jtk, rtk, js;
        int n;
        ss = 4'(rnd() % 3);
        si = rng[7:0];
        c = 16'(rnd());
        t = 16'(rnd());
        cd = rng[20];
        js = rng[21];
        slow <= rng[9];
        a2 = a + 16'h0064;
        of = a > 16'hFF9B;
        e = (imf && op == 4'h4) ? {1'b0, b} : alu_exp(op, a2, b);
        res = e[15:0];
        zf = res == 16'h0;
        if (op < 4'h2) of = e[16];
        jtk = jt == 3'h0 || (jt == 3'h1 && zf) || (jt == 3'h2 && of);
        rtk = cd ? c >= t : c < t;
        lpcx_ram_model_inst.mem[0] = {4'h7, 3'h2, ss, 9'h0, si, 4'h0};
        lpcx_ram_model_inst.mem[1] = {4'h7, 3'h1, 4'h4, 1'h0, 16'h0064, 2'h0, 2'h3};
        lpcx_ram_model_inst.mem[2] = {4'h7, 3'h1, 4'h0, 1'h0, a, 2'h3, 2'h0};
        lpcx_ram_model_inst.mem[3] = {4'h7, 3'h1, 4'h4, 1'h0, b, 2'h0, 2'h1};
        lpcx_ram_model_inst.mem[4] = imf ? {4'h7, 3'h1, op, 1'h0, b, 2'h0, 2'h2}
            : {4'h7, 3'h0, op, 15'h0, 2'h1, 2'h0, 2'h2};
        lpcx_ram_model_inst.mem[5] = {4'h6, 3'h4, 5'h0, 10'h3FE, 6'h0, 2'h3, 2'h2};
        lpcx_ram_model_inst.mem[6] = {4'h8, 3'h0, jt, js, 6'h0, 13'h0008, 2'h3};
        lpcx_ram_model_inst.mem[7] = {4'h6, 3'h4, 5'h0, 10'h001, 6'h0, 2'h3, 2'h0};
        lpcx_ram_model_inst.mem[8] = {4'hD, 3'h0, 5'h0, 10'h005, 6'h0, 2'h3, 2'h0};
        lpcx_ram_model_inst.mem[9] = {4'h8, 3'h1, 8'h02, cd, t};
        lpcx_ram_model_inst.mem[10] = {4'h6, 3'h4, 5'h0, 10'h002, 6'h0, 2'h3, 2'h0};
        lpcx_ram_model_inst.mem[11] = {4'h8, 3'h0, 3'h0, 1'h0, 6'h0, 13'h000B, 2'h0};
        foreach (lpcx_ram_model_inst.mem[i]) if (i > 11) lpcx_ram_model_inst.mem[i] = FILL;
        // Register target is R3 (100); that word leads back into the store at 7
        lpcx_ram_model_inst.mem[100] = {4'h8, 3'h0, 3'h0, 1'h0, 6'h0, 13'h0007, 2'h0};
        lpcx_ram_model_inst.mem[105] = {~c, c};
        reg_wr(3'h4, 16'h0);
        reg_wr(3'h7, 16'h1);
        for (n = 0; n < 800 && !(mem_valid_out && !mem_req_out.we && mem_req_out.addr == 11'd11); n++)
            @(posedge clk_in);
        if (n == 800) begin
            fail_count++; // Hung program counts and the run still reaches its verdict
            return;
        end
        reg_wr(3'h7, 16'h0);
        reg_wr(3'h0, 16'hFFFF);
        reg_chk(3'h0, c);
        reg_chk(3'h1, b);
        reg_chk(3'h2, res);
        reg_chk(3'h3, 16'h0064);
        reg_chk(3'h4, 16'h000B);
        reg_chk(3'h5, {8'h0, lpcx_core_test_stage});
        reg_chk(3'h6, {14'h0, of, zf});
        check(lpcx_ram_model_inst.mem[98], {16'h00A0, res});
        check(lpcx_ram_model_inst.mem[101], (jtk && !js) ? FILL : {16'h00E0, a2});
        check(lpcx_ram_model_inst.mem[102], rtk ? FILL : {16'h0140, c});
        $display("trial op %0d form %0d jump %0d done", op, imf, jt);
    endtask : trial
    // Reset, hand-picked corners, then random trials
    initial begin
        rng = 32'd11460;
        {rst_in, reg_we_in, reg_re_in, slow} = 4'b1000;
        reg_addr_in = 3'h0;
        reg_wdata_in = 16'h0;
        lpcx_core_test_stage = 8'h0;
        fail_count = 0;
        checked = 0;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        trial(4'h0, 16'hFF9B, 16'h0001, 1'b0, 3'h2);
        trial(4'h1, 16'h1234, 16'h1298, 1'b1, 3'h1);
        trial(4'h1, 16'hFF9C, 16'h5000, 1'b0, 3'h2);
        for (int i = 0; i < 21; i++) begin
            ra = 16'(rnd());
            rb = (i % 7 > 4) ? 16'(rnd() % 20) : 16'(rnd());
            trial(4'(i % 7), ra, rb, rng[3], 3'(rng[9:8]));
        end
        complete_run();
    end
    // Stage counter expectation follows each stage instruction fetched from word 0
    always @(posedge clk_in) if (mem_rvalid_in && mem_rdata_in[31:25] == 7'h3A && mem_req_out.addr == 11'd0)
        lpcx_core_test_stage <= mem_rdata_in[24:21] == 4'h0 ? lpcx_core_test_stage + mem_rdata_in[11:4]
            : mem_rdata_in[24:21] == 4'h1 ? lpcx_core_test_stage - mem_rdata_in[11:4] : 8'h0;
endmodule : lpcx_core_test
